// >>> core/irq_enable_map.svh
// Offsets, field positions, reset values and constants of the enable bank.
// Assumes a 32-bit classic Wishbone slave, one aligned word per register.
`ifndef IRQ_ENABLE_MAP_SVH
`define IRQ_ENABLE_MAP_SVH

`define EN_TWO_OFS 8'h00
`define EN_FOUR_OFS 8'h04
`define IRQ_STAT_OFS 8'h08
`define IRQ_MASK_OFS 8'h0C
`define GATED_OFS 8'h10

`define EN_TWO_RST 16'h0000
`define EN_FOUR_RST 16'h0000
`define EN_TWO_MASK 16'h6000
`define EN_FOUR_MASK 16'h007E

`define BIT_CAL 14
`define BIT_DMA5 13
`define BIT_CANTX 6
`define BIT_DMA7 5
`define BIT_DMA6 4
`define BIT_CRC 3
`define BIT_SER2 2
`define BIT_SER1 1

`define NUM_SRC 8
`define BUS_ERR_DATA 32'h0000_0000

`endif

// >>> core/irq_enable_pkg.sv
// Types shared by the enable bank files.
// Assumes the map header is compiled alongside it.
package irq_enable_pkg;

  // One pending flag per source, in fixed order.
  typedef struct packed {
    logic calendar;
    logic dma5;
    logic can_tx;
    logic dma7;
    logic dma6;
    logic checksum;
    logic serial2;
    logic serial1;
  } src_vec_t;

  // Wishbone request bundle.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage : irq_enable_pkg

// >>> core/irq_gate.sv
// Combinational AND of pending flags with their enable bits.
// Assumes flags and enables are both synchronous to the system clock.
`timescale 1ns/1ps
module irq_gate
  import irq_enable_pkg::*;
(
  // Sources and enables.
  input wire src_vec_t pend_i,
  input wire src_vec_t en_i,
  // Gated requests.
  output src_vec_t gated_o
);

  // One AND per source, with no registering, so it follows every cycle.
  assign gated_o = pend_i & en_i;

endmodule : irq_gate

// >>> core/irq_enable_bank.sv
// Two interrupt enable registers with gating, reached over classic Wishbone.
// Assumes pending flags arrive synchronous to clk_i from the flag logic.
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "irq_enable_map.svh"
module irq_enable_bank
  import irq_enable_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Interrupt sources and gated requests.
  input wire src_vec_t pend_i,
  output src_vec_t gated_o,
  output logic irq_o
);

  logic [15:0] en_two_ff, nxt_en_two;
  logic [15:0] en_four_ff, nxt_en_four;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] mask_ff, nxt_mask;
  logic ack_ff, nxt_ack;
  logic err_ff, nxt_err;
  logic [31:0] rdat_ff, nxt_rdat;
  src_vec_t en_vec, gated_raw, pend_eff, gated_q;
  logic req, wr, hit;

  // Merge a write with byte enables into the low 16 bits of a register.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel, input logic [15:0] m);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    merge16 = r & m;
  endfunction : merge16

  // CAN transmit is forced off on variants without the controller.
  assign pend_eff = HAS_CAN ? pend_i : (pend_i & ~src_vec_t'(8'h20));
  assign en_vec = '{
    calendar: en_two_ff[`BIT_CAL],
    dma5: en_two_ff[`BIT_DMA5],
    can_tx: HAS_CAN & en_four_ff[`BIT_CANTX],
    dma7: en_four_ff[`BIT_DMA7],
    dma6: en_four_ff[`BIT_DMA6],
    checksum: en_four_ff[`BIT_CRC],
    serial2: en_four_ff[`BIT_SER2],
    serial1: en_four_ff[`BIT_SER1]
  };

  irq_gate u_gate (
    .pend_i(pend_eff),
    .en_i(en_vec),
    .gated_o(gated_raw)
  );

  // Gated requests go out combinationally so the priority logic sees them at once.
  assign gated_o = gated_raw;
  assign irq_o = |(stat_ff & mask_ff);
  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;
  assign wb_dat_o = rdat_ff;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
  assign wr = req & wb_we_i;
  assign hit = (wb_adr_i == `EN_TWO_OFS) || (wb_adr_i == `EN_FOUR_OFS) ||
               (wb_adr_i == `IRQ_STAT_OFS) || (wb_adr_i == `IRQ_MASK_OFS) ||
               (wb_adr_i == `GATED_OFS);

  // Next state of registers and bus answer; one-cycle answer after the request.
  always_comb begin
    nxt_en_two = en_two_ff;
    nxt_en_four = en_four_ff;
    nxt_mask = mask_ff;
    nxt_ack = req & hit;
    nxt_err = req & ~hit;
    nxt_rdat = rdat_ff;
    // Sticky status: a hardware set wins over a same-cycle clear.
    nxt_stat = stat_ff;
    if (wr && wb_adr_i == `IRQ_STAT_OFS && wb_sel_i[0]) begin
      nxt_stat = stat_ff & ~wb_dat_i[7:0];
    end
    nxt_stat = nxt_stat | gated_raw;
    if (wr) begin
      case (wb_adr_i)
        `EN_TWO_OFS: nxt_en_two = merge16(en_two_ff, wb_dat_i, wb_sel_i, `EN_TWO_MASK);
        `EN_FOUR_OFS: nxt_en_four = merge16(en_four_ff, wb_dat_i, wb_sel_i, `EN_FOUR_MASK);
        `IRQ_MASK_OFS: begin
          if (wb_sel_i[0]) begin
            nxt_mask = wb_dat_i[7:0];
          end
        end
        default: nxt_mask = mask_ff;
      endcase
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `EN_TWO_OFS: nxt_rdat = {16'h0000, en_two_ff};
        `EN_FOUR_OFS: nxt_rdat = {16'h0000, en_four_ff};
        `IRQ_STAT_OFS: nxt_rdat = {24'h000000, stat_ff};
        `IRQ_MASK_OFS: nxt_rdat = {24'h000000, mask_ff};
        `GATED_OFS: nxt_rdat = {24'h000000, gated_raw};
        default: nxt_rdat = `BUS_ERR_DATA;
      endcase
    end
  end

  // Registers only; reset clears every enable bit.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      en_two_ff <= `EN_TWO_RST;
      en_four_ff <= `EN_FOUR_RST;
      stat_ff <= 8'h00;
      mask_ff <= 8'h00;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      en_two_ff <= nxt_en_two;
      en_four_ff <= nxt_en_four;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      rdat_ff <= nxt_rdat;
    end
  end

  assign gated_q = gated_raw;

  property p_cal_gate;
    @(posedge clk_i) disable iff (srst_i)
      gated_o.calendar == (pend_i.calendar & en_two_ff[`BIT_CAL]);
  endproperty
  a_cal_gate: assert property (p_cal_gate) else $error("calendar gate wrong");

  property p_dma5_gate;
    @(posedge clk_i) disable iff (srst_i)
      (wr && wb_adr_i == `EN_TWO_OFS && wb_sel_i[1] && wb_dat_i[13]) |=>
        (pend_i.dma5 |-> gated_o.dma5);
  endproperty
  a_dma5_gate: assert property (p_dma5_gate) else $error("dma5 not passed");

  property p_two_unimpl;
    @(posedge clk_i) disable iff (srst_i)
      (en_two_ff & ~`EN_TWO_MASK) == 16'h0000;
  endproperty
  a_two_unimpl: assert property (p_two_unimpl) else $error("unimplemented bit set");

  property p_blocked;
    @(posedge clk_i) disable iff (srst_i)
      (gated_o & ~en_vec) == 8'h00;
  endproperty
  a_blocked: assert property (p_blocked) else $error("disabled source passed");

  property p_no_can;
    @(posedge clk_i) disable iff (srst_i)
      !HAS_CAN |-> !gated_o.can_tx;
  endproperty
  a_no_can: assert property (p_no_can) else $error("can request without controller");

  property p_reset_clear;
    @(posedge clk_i) srst_i |=> (en_two_ff == 16'h0000 && en_four_ff == 16'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not cleared");

  property p_dma6_gate;
    @(posedge clk_i) disable iff (srst_i)
      gated_o.dma6 == (pend_i.dma6 & en_four_ff[`BIT_DMA6]);
  endproperty
  a_dma6_gate: assert property (p_dma6_gate) else $error("dma6 gate wrong");

  property p_crc_gate;
    @(posedge clk_i) disable iff (srst_i)
      (pend_i.checksum && $past(en_four_ff[`BIT_CRC]) && $stable(en_four_ff)) |-> gated_o.checksum;
  endproperty
  a_crc_gate: assert property (p_crc_gate) else $error("checksum gate wrong");

  property p_stat_follow;
    @(posedge clk_i) disable iff (srst_i)
      (gated_q != 8'h00) |=> ((stat_ff & $past(gated_q)) == $past(gated_q));
  endproperty
  a_stat_follow: assert property (p_stat_follow) else $error("gated event lost");

endmodule : irq_enable_bank

// >>> testbench/irq_enable_bank_test.sv
// Self-checking bench for the enable bank, driven over classic Wishbone.
// Assumes the map header and the package are compiled before this file.
`timescale 1ns/1ps
`include "irq_enable_map.svh"
module irq_enable_bank_test;
  import irq_enable_pkg::*;
  // Stimulus and observed signals.
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, got;
  logic ack, err, irq, got_err;
  src_vec_t pend = 8'h00, gated, gated_nc;
  int failures = 0;
  int tests_run = 0;

  // Full device and a variant without the CAN controller share one bus.
  irq_enable_bank uut (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .pend_i(pend), .gated_o(gated), .irq_o(irq));
  irq_enable_bank #(.HAS_CAN(1'b0)) uut_nocan (.clk_i(clk_i), .srst_i(srst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(), .wb_err_o(), .pend_i(pend),
    .gated_o(gated_nc), .irq_o());

  // Clock at 50 ns period.
  always #25 clk_i = ~clk_i;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask : check

  // One classic cycle; the wait is bounded so a silent slave cannot hang us.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    got = rdat;
    got_err = err;
    check("answer", 32'h1, {31'h0, ack | err});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    check(what, exp, got);
  endtask : rd

  task automatic t_reset();
    rd(`EN_TWO_OFS, 32'h0000_0000, "two_rst");
    rd(`EN_FOUR_OFS, 32'h0000_0000, "four_rst");
    rd(`IRQ_MASK_OFS, 32'h0000_0000, "mask_rst");
    $display("test reset done");
  endtask : t_reset

  // Unimplemented bits must drop writes of all ones.
  task automatic t_access();
    bus(1'b1, `EN_TWO_OFS, 32'h0000_FFFF);
    rd(`EN_TWO_OFS, 32'h0000_6000, "two_ones");
    bus(1'b1, `EN_FOUR_OFS, 32'h0000_FFFF);
    rd(`EN_FOUR_OFS, 32'h0000_007E, "four_ones");
    bus(1'b1, `EN_TWO_OFS, 32'h0000_0000);
    bus(1'b1, `EN_FOUR_OFS, 32'h0000_0000);
    rd(`EN_TWO_OFS, 32'h0000_0000, "two_zero");
    $display("test access done");
  endtask : t_access

  // Walk one enable at a time with every flag pending.
  task automatic t_gate();
    logic [7:0] a;
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      a = (i >= 6) ? `EN_TWO_OFS : `EN_FOUR_OFS;
      v = (i >= 6) ? 16'h2000 << (i - 6) : 16'h0002 << i;
      pend <= 8'hFF;
      bus(1'b1, a, {16'h0000, v});
      check("gated", 32'h1 << i, {24'h0, gated});
      check("gated_nocan", (i == 5) ? 32'h0 : 32'h1 << i, {24'h0, gated_nc});
      rd(`GATED_OFS, 32'h1 << i, "gated_view");
      @(posedge clk_i);
      pend <= 8'h00;
      @(posedge clk_i);
      #1;
      check("gated_idle", 32'h0, {24'h0, gated});
      bus(1'b1, a, 32'h0000_0000);
    end
    $display("test gate done");
  endtask : t_gate

  // Sticky status, mask and level output.
  task automatic t_irq();
    check("irq_masked", 32'h0, {31'h0, irq});
    rd(`IRQ_STAT_OFS, 32'h0000_00FF, "status");
    bus(1'b1, `IRQ_MASK_OFS, 32'h0000_0080);
    check("irq_on", 32'h1, {31'h0, irq});
    bus(1'b1, `IRQ_STAT_OFS, 32'h0000_00FF);
    rd(`IRQ_STAT_OFS, 32'h0000_0000, "status_clr");
    check("irq_off", 32'h0, {31'h0, irq});
    bus(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped_err", 32'h1, {31'h0, got_err});
    check("unmapped_dat", `BUS_ERR_DATA, got);
    $display("test irq done");
  endtask : t_irq

  // A reset in mid-run must clear enables, mask and status that were set beforehand.
  task automatic t_midreset();
    bus(1'b1, `EN_TWO_OFS, 32'h0000_FFFF);
    bus(1'b1, `EN_FOUR_OFS, 32'h0000_FFFF);
    bus(1'b1, `IRQ_MASK_OFS, 32'h0000_00FF);
    pend <= 8'hFF;
    @(posedge clk_i);
    srst_i <= 1'b1;
    pend <= 8'h00;
    @(posedge clk_i);
    check("irq_pre_rst", 32'h1, {31'h0, irq});
    @(posedge clk_i);
    srst_i <= 1'b0;
    check("irq_rst", 32'h0, {31'h0, irq});
    rd(`EN_TWO_OFS, 32'h0000_0000, "two_midrst");
    rd(`EN_FOUR_OFS, 32'h0000_0000, "four_midrst");
    rd(`IRQ_MASK_OFS, 32'h0000_0000, "mask_midrst");
    rd(`IRQ_STAT_OFS, 32'h0000_0000, "status_midrst");
    $display("test midreset done");
  endtask : t_midreset

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_access();
    t_gate();
    t_irq();
    t_midreset();
    conclude();
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #(3000 * 50);
    failures++;
    conclude();
  end
endmodule : irq_enable_bank_test
